/* rtl/nam_top.sv */
// Behaviour
// (R1) unbalance alarm on three-phase only, current spread above threshold percent of nominal
// (R2) unbalance threshold writes outside five to fifty percent are ignored
// (R3) capture request stores a reference impedance per phase
// (R4) partial failure compares measured impedance to reference scaled by sensitivity
// (R5) comparison window: mains cycle in phase angle, burst period otherwise
// (R6) three-phase reference capture accepted only with balanced currents
// (R7) no partial failure detection or capture below thirty percent nominal voltage or current
// (R8) star-with-neutral and open delta use measured voltage and current directly
// (R9) star-without-neutral and closed delta use equivalent line-to-line impedance
// (R10) each of sixteen alarm types has its own disable bit
// (R11) detect status true only while the condition is present
// (R12) signal reports occurrence, held after the condition if latching
// (R13) each alarm individually latching or non-latching
// (R14) acknowledge write clears that alarm's signal
// (R15) acknowledge bits self-clear after the write
// (R16) acknowledge ignored while the condition is still active
// (R17) stop-configured alarm with signal set inhibits firing
// (R18) over current when load current exceeds threshold percent of nominal
// (R19) capture done flag set when reference measurement succeeds
// (R20) disabled alarm never shows detect, signal or stop
// (R21) non-latching signal follows detect and clears with it
`timescale 1ns/1ns
module nam_top (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   meas_valid,
  input  wire nam_pkg::nam_meas_t     meas,
  input  wire logic                   mains_cycle_end,
  input  wire logic                   burst_end,
  input  wire logic [nam_pkg::ALARM_N-1:0] alarm_cond_in,
  output logic                        stop_fire,
  output logic [nam_pkg::ALARM_N-1:0] alarm_detect_set,
  output logic [nam_pkg::ALARM_N-1:0] alarm_signal_set,
  output logic                        ref_capture_done
);
  localparam int AN  = nam_pkg::ALARM_N;
  localparam int NPH = nam_pkg::NPH;
  localparam int SW  = nam_pkg::SMP_W;
  localparam int AW  = nam_pkg::ACC_W;
  localparam int ZW  = nam_pkg::Z_W;
  localparam int DW  = nam_pkg::DVD_W;

  function automatic logic [31:0] mul_pct(input logic [SW-1:0] x, input logic [8:0] p);
    mul_pct = {16'h0000, x} * {23'h000000, p};
  endfunction

  function automatic logic [nam_pkg::SCL_W-1:0] scale_v(input logic [AW-1:0] v,
                                                         input logic [9:0]    k);
    logic [AW+9:0] prod;
    prod    = {10'h000, v} * {{AW{1'b0}}, k};
    scale_v = prod[AW+9:8];
  endfunction

  nam_pkg::nam_net_t  net_r;
  nam_pkg::nam_fire_t fire_r;
  logic [SW-1:0]      v_nom_r;
  logic [SW-1:0]      i_nom_r;
  logic [7:0]         unb_thr_r;
  logic [8:0]         oc_thr_r;
  logic [3:0]         sens_r;
  logic [AN-1:0]      dis_r;
  logic [AN-1:0]      lat_r;
  logic [AN-1:0]      stop_cfg_r;
  logic [AN-1:0]      ack_r;
  logic               cap_req_r;
  logic               bus_req;
  logic               wr_en;
  logic [31:0]        rd_nxt;
  logic               three_ph;
  logic [NPH-1:0]     used;
  logic [SW-1:0]      i_max;
  logic [SW-1:0]      i_min;
  logic               lvl_ok;
  logic               bal_ok;
  logic               win_end;
  logic [NPH-1:0][AW-1:0] vacc_r;
  logic [NPH-1:0][AW-1:0] iacc_r;
  logic [NPH-1:0][DW-1:0] dvd;
  logic [NPH-1:0][DW-1:0] quo;
  logic [NPH-1:0]     div_done;
  logic [NPH-1:0][ZW-1:0] z_meas;
  logic [NPH-1:0][ZW-1:0] zref_r;
  logic               div_busy_r;
  logic               win_lvl_r;
  logic               win_bal_r;
  logic               cap_pend_r;
  logic               ref_valid_r;
  logic               plf_cond_r;
  logic               unb_cond_r;
  logic               oc_cond_r;
  logic               plf_hit;
  logic [9:0]         k_sel;
  logic               win_cap_r;
  logic [AN-1:0]      cond;
  logic [AN-1:0]      det_nxt;
  logic [AN-1:0]      sig_nxt;
  assign bus_req = avs_read | avs_write;
  assign wr_en   = avs_write & ~avs_waitrequest;
  // one wait state: waitrequest drops for a single cycle per request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_address)
      nam_pkg::REG_CTRL:   rd_nxt = {26'h0, fire_r, 1'b0, net_r};
      nam_pkg::REG_V_NOM:  rd_nxt = {16'h0000, v_nom_r};
      nam_pkg::REG_I_NOM:  rd_nxt = {16'h0000, i_nom_r};
      nam_pkg::REG_UNB:    rd_nxt = {24'h000000, unb_thr_r};
      nam_pkg::REG_OC:     rd_nxt = {23'h000000, oc_thr_r};
      nam_pkg::REG_SENS:   rd_nxt = {28'h0000000, sens_r};
      nam_pkg::REG_DIS:    rd_nxt = {16'h0000, dis_r};
      nam_pkg::REG_LATCH:  rd_nxt = {16'h0000, lat_r};
      nam_pkg::REG_STOP:   rd_nxt = {16'h0000, stop_cfg_r};
      nam_pkg::REG_DETECT: rd_nxt = {16'h0000, alarm_detect_set};
      nam_pkg::REG_SIGNAL: rd_nxt = {16'h0000, alarm_signal_set};
      nam_pkg::REG_STATUS: rd_nxt = {29'h0, cap_pend_r, ref_valid_r, ref_capture_done};
      4'hD, 4'hE, 4'hF:    rd_nxt = {16'h0000, zref_r[avs_address - nam_pkg::REG_ZREF0]};
      default:             rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data captured with the answer, holds until the next read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && avs_waitrequest) begin
      avs_readdata <= rd_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      net_r      <= nam_pkg::NAM_NET_4S;
      fire_r     <= nam_pkg::NAM_FIRE_PA;
      v_nom_r    <= nam_pkg::V_NOM_RST;
      i_nom_r    <= nam_pkg::I_NOM_RST;
      unb_thr_r  <= nam_pkg::UNB_RST;
      oc_thr_r   <= nam_pkg::OC_RST;
      sens_r     <= nam_pkg::SENS_RST;
      dis_r      <= '0;
      lat_r      <= '0;
      stop_cfg_r <= '0;
    end else if (ce && wr_en) begin
      case (avs_address)
        nam_pkg::REG_CTRL: begin
          net_r  <= nam_pkg::nam_net_t'(avs_writedata[nam_pkg::CTRL_NET_LSB +: 3]);
          fire_r <= nam_pkg::nam_fire_t'(avs_writedata[nam_pkg::CTRL_FIRE_LSB +: 2]);
        end
        nam_pkg::REG_V_NOM: v_nom_r <= avs_writedata[SW-1:0];
        nam_pkg::REG_I_NOM: i_nom_r <= avs_writedata[SW-1:0];
        nam_pkg::REG_UNB: begin
          if (avs_writedata[7:0] >= nam_pkg::UNB_MIN && avs_writedata[7:0] <= nam_pkg::UNB_MAX &&
              avs_writedata[31:8] == 24'h000000) begin
            unb_thr_r <= avs_writedata[7:0]; // [R2]
          end
        end
        nam_pkg::REG_OC: oc_thr_r <= avs_writedata[8:0];
        nam_pkg::REG_SENS: if (avs_writedata[3:0] >= nam_pkg::SENS_MIN)
          sens_r <= avs_writedata[3:0];
        nam_pkg::REG_DIS:   dis_r      <= avs_writedata[AN-1:0]; // [R10]
        nam_pkg::REG_LATCH: lat_r      <= avs_writedata[AN-1:0]; // [R13]
        nam_pkg::REG_STOP:  stop_cfg_r <= avs_writedata[AN-1:0];
        default: ;
      endcase
    end
  end

  // acknowledge and capture request are write pulses, never stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r     <= '0;
      cap_req_r <= 1'b0;
    end else if (ce) begin
      ack_r     <= (wr_en && avs_address == nam_pkg::REG_ACK) ?
                   avs_writedata[AN-1:0] : '0; // [R15]
      cap_req_r <= wr_en && avs_address == nam_pkg::REG_CTRL &&
                   avs_writedata[nam_pkg::CTRL_CAP_BIT]; // [R3]
    end
  end

  assign three_ph = (net_r != nam_pkg::NAM_NET_1PH);
  assign used     = three_ph ? 3'b111 : 3'b001;

  always_comb begin
    i_max  = meas.i[0];
    i_min  = meas.i[0];
    lvl_ok = 1'b1;
    for (int p = 0; p < NPH; p++) begin
      if (used[p]) begin
        if (meas.i[p] > i_max) i_max = meas.i[p];
        if (meas.i[p] < i_min) i_min = meas.i[p];
        if (mul_pct(meas.v[p], nam_pkg::PCT_FULL) < mul_pct(v_nom_r, nam_pkg::MIN_LVL_PCT) ||
            mul_pct(meas.i[p], nam_pkg::PCT_FULL) < mul_pct(i_nom_r, nam_pkg::MIN_LVL_PCT)) begin
          lvl_ok = 1'b0; // [R7]
        end
      end
    end
  end

  assign bal_ok = mul_pct(SW'(i_max - i_min), nam_pkg::PCT_FULL) <=
                  mul_pct(i_nom_r, {1'b0, unb_thr_r});

  // unbalance and over current follow each new sample
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unb_cond_r <= 1'b0;
      oc_cond_r  <= 1'b0;
    end else if (ce && meas_valid) begin
      unb_cond_r <= three_ph && !bal_ok; // [R1]
      oc_cond_r  <= mul_pct(i_max, nam_pkg::PCT_FULL) > mul_pct(i_nom_r, oc_thr_r); // [R18]
    end
  end

  assign win_end = (fire_r == nam_pkg::NAM_FIRE_PA) ? mains_cycle_end : burst_end; // [R5]
  // sums over the window; ratio of sums is the impedance, so sample count cancels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vacc_r <= '0;
      iacc_r <= '0;
    end else if (ce) begin
      for (int p = 0; p < NPH; p++) begin
        if (win_end) begin
          vacc_r[p] <= meas_valid ? AW'(meas.v[p]) : '0;
          iacc_r[p] <= meas_valid ? AW'(meas.i[p]) : '0;
        end else if (meas_valid) begin
          vacc_r[p] <= vacc_r[p] + AW'(meas.v[p]);
          iacc_r[p] <= iacc_r[p] + AW'(meas.i[p]);
        end
      end
    end
  end

  always_comb begin
    case (net_r)
      nam_pkg::NAM_NET_3S: k_sel = nam_pkg::K_STAR;  // [R9]
      nam_pkg::NAM_NET_3D: k_sel = nam_pkg::K_DELTA; // [R9]
      default:             k_sel = nam_pkg::K_UNITY; // [R8]
    endcase
  end

  for (genvar p = 0; p < NPH; p++) begin : g_ph
    assign dvd[p]    = {scale_v(vacc_r[p], k_sel), {nam_pkg::ZFRAC{1'b0}}};
    assign z_meas[p] = (|quo[p][DW-1:ZW]) ? {ZW{1'b1}} : quo[p][ZW-1:0];
    nam_div #(
      .DW (DW),
      .VW (AW)
    ) u_div (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .ce       (ce),
      .start    (win_end && !div_busy_r),
      .dividend (dvd[p]),
      .divisor  (iacc_r[p]),
      .done     (div_done[p]),
      .quotient (quo[p])
    );
  end

  // windows ending mid-divide are skipped; capture only from a window ending after the request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_busy_r <= 1'b0;
      win_lvl_r  <= 1'b0;
      win_bal_r  <= 1'b0;
      win_cap_r  <= 1'b0;
    end else if (ce) begin
      if (win_end && !div_busy_r) begin
        div_busy_r <= 1'b1;
        win_cap_r  <= cap_pend_r; // [R3]
        win_lvl_r  <= lvl_ok;
        win_bal_r  <= bal_ok || !three_ph;
      end else if (&div_done) begin
        div_busy_r <= 1'b0;
      end
    end
  end

  always_comb begin
    plf_hit = 1'b0;
    for (int p = 0; p < NPH; p++) begin
      if (used[p] && zref_r[p] != '0 &&
          {4'h0, z_meas[p]} * {{ZW{1'b0}}, sens_r - 4'h1} >=
          {4'h0, zref_r[p]} * {{ZW{1'b0}}, sens_r}) begin
        plf_hit = 1'b1; // [R4]
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      zref_r           <= '0;
      cap_pend_r       <= 1'b0;
      ref_valid_r      <= 1'b0;
      ref_capture_done <= 1'b0;
      plf_cond_r       <= 1'b0;
    end else if (ce) begin
      if (&div_done) begin
        if (win_cap_r) begin
          cap_pend_r <= 1'b0;
          if (win_lvl_r && win_bal_r) begin // [R6] [R7]
            for (int p = 0; p < NPH; p++) begin
              zref_r[p] <= used[p] ? z_meas[p] : '0; // [R3]
            end
            ref_valid_r      <= 1'b1;
            ref_capture_done <= 1'b1; // [R19]
            plf_cond_r       <= 1'b0;
          end
        end else begin
          plf_cond_r <= ref_valid_r && win_lvl_r && plf_hit; // [R4] [R7]
        end
      end
      // a fresh request restarts capture and withdraws the old done flag
      if (cap_req_r) begin
        cap_pend_r       <= 1'b1;
        ref_capture_done <= 1'b0;
      end
    end
  end

  always_comb begin
    cond                         = alarm_cond_in;
    cond[nam_pkg::ALM_PART_FAIL] = plf_cond_r;
    cond[nam_pkg::ALM_UNBALANCE] = unb_cond_r;
    cond[nam_pkg::ALM_OVER_I]    = oc_cond_r;
    det_nxt                      = cond & ~dis_r; // [R20] [R11]
    for (int a = 0; a < AN; a++) begin
      if (dis_r[a]) begin
        sig_nxt[a] = 1'b0; // [R20]
      end else if (det_nxt[a]) begin
        sig_nxt[a] = 1'b1; // [R12] [R16]
      end else if (!lat_r[a]) begin
        sig_nxt[a] = 1'b0; // [R21]
      end else if (ack_r[a]) begin
        sig_nxt[a] = 1'b0; // [R14]
      end else begin
        sig_nxt[a] = alarm_signal_set[a]; // [R12] [R13]
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_detect_set <= '0;
      alarm_signal_set <= '0;
      stop_fire        <= 1'b0;
    end else if (ce) begin
      alarm_detect_set <= det_nxt; // [R11]
      alarm_signal_set <= sig_nxt;
      stop_fire        <= |(sig_nxt & stop_cfg_r); // [R17]
    end
  end
endmodule // nam_top

/* rtl/nam_pkg.sv */
package nam_pkg;

  localparam int ALARM_N   = 16;
  localparam int NPH       = 3;
  localparam int SMP_W     = 16;
  localparam int ACC_W     = 32;
  localparam int Z_W       = 16;
  localparam int ZFRAC     = 8;
  localparam int SCL_W     = ACC_W + 2;
  localparam int DVD_W     = SCL_W + ZFRAC;

  // alarm bit positions
  localparam int ALM_MISS_MAINS = 0;
  localparam int ALM_THYR_SC    = 1;
  localparam int ALM_THYR_OPEN  = 2;
  localparam int ALM_FUSE       = 3;
  localparam int ALM_OVER_TEMP  = 4;
  localparam int ALM_VOLT_DIPS  = 5;
  localparam int ALM_FREQ       = 6;
  localparam int ALM_PSU_24V    = 7;
  localparam int ALM_TOTAL_FAIL = 8;
  localparam int ALM_CHOP_OFF   = 9;
  localparam int ALM_PART_FAIL  = 10;
  localparam int ALM_UNBALANCE  = 11;
  localparam int ALM_VOLT_FAULT = 12;
  localparam int ALM_PRE_TEMP   = 13;
  localparam int ALM_OVER_I     = 14;
  localparam int ALM_SPARE      = 15;

  // register word indices
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_V_NOM  = 4'h1;
  localparam logic [3:0] REG_I_NOM  = 4'h2;
  localparam logic [3:0] REG_UNB    = 4'h3;
  localparam logic [3:0] REG_OC     = 4'h4;
  localparam logic [3:0] REG_SENS   = 4'h5;
  localparam logic [3:0] REG_DIS    = 4'h6;
  localparam logic [3:0] REG_LATCH  = 4'h7;
  localparam logic [3:0] REG_STOP   = 4'h8;
  localparam logic [3:0] REG_ACK    = 4'h9;
  localparam logic [3:0] REG_DETECT = 4'hA;
  localparam logic [3:0] REG_SIGNAL = 4'hB;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam logic [3:0] REG_ZREF0  = 4'hD;

  // control register fields
  localparam int CTRL_NET_LSB  = 0;
  localparam int CTRL_FIRE_LSB = 4;
  localparam int CTRL_CAP_BIT  = 8;

  // reset values and limits; unbalance, over current and level figures in percent of nominal
  localparam logic [15:0] V_NOM_RST   = 16'h1000;
  localparam logic [15:0] I_NOM_RST   = 16'h1000;
  localparam logic [7:0]  UNB_RST     = 8'h14;
  localparam logic [7:0]  UNB_MIN     = 8'h05;
  localparam logic [7:0]  UNB_MAX     = 8'h32;
  localparam logic [8:0]  OC_RST      = 9'h078;
  localparam logic [3:0]  SENS_RST    = 4'h2;
  localparam logic [3:0]  SENS_MIN    = 4'h2;
  localparam logic [8:0]  MIN_LVL_PCT = 9'h01E;
  localparam logic [8:0]  PCT_FULL    = 9'h064;

  // equivalent impedance scale, 8 fractional bits: 1/sqrt3 and sqrt3
  localparam logic [9:0]  K_UNITY = 10'h100;
  localparam logic [9:0]  K_STAR  = 10'h094;
  localparam logic [9:0]  K_DELTA = 10'h1BB;

  typedef enum logic [2:0] {
    NAM_NET_1PH = 3'h0,
    NAM_NET_3S  = 3'h1,
    NAM_NET_4S  = 3'h2,
    NAM_NET_3D  = 3'h3,
    NAM_NET_6D  = 3'h4
  } nam_net_t;

  typedef enum logic [1:0] {
    NAM_FIRE_PA    = 2'h0,
    NAM_FIRE_BURST = 2'h1,
    NAM_FIRE_LOGIC = 2'h2
  } nam_fire_t;

  typedef struct packed {
    logic [NPH-1:0][SMP_W-1:0] v;
    logic [NPH-1:0][SMP_W-1:0] i;
  } nam_meas_t;

endpackage

/* rtl/nam_div.sv */
`timescale 1ns/1ns
module nam_div #(
  parameter int DW = 42,
  parameter int VW = 32
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          start,
  input  wire logic [DW-1:0] dividend,
  input  wire logic [VW-1:0] divisor,
  output logic               done,
  output logic [DW-1:0]      quotient
);
  localparam int CW = $clog2(DW + 1);

  logic [VW-1:0] rem_r;
  logic [VW-1:0] dvs_r;
  logic [DW-1:0] dvd_r;
  logic [CW-1:0] cnt_r;
  logic          busy_r;
  logic [VW:0]   trial;

  assign trial = {rem_r, dvd_r[DW-1]};

  // restoring division, one quotient bit per cycle; zero divisor saturates
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r    <= '0;
      dvs_r    <= '0;
      dvd_r    <= '0;
      cnt_r    <= '0;
      busy_r   <= 1'b0;
      done     <= 1'b0;
      quotient <= '0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy_r) begin
        busy_r   <= 1'b1;
        cnt_r    <= CW'(DW);
        rem_r    <= '0;
        dvd_r    <= dividend;
        dvs_r    <= divisor;
        quotient <= '0;
      end else if (busy_r) begin
        dvd_r <= {dvd_r[DW-2:0], 1'b0};
        cnt_r <= cnt_r - 1'b1;
        if (trial >= {1'b0, dvs_r}) begin
          rem_r    <= VW'(trial - {1'b0, dvs_r});
          quotient <= {quotient[DW-2:0], 1'b1};
        end else begin
          rem_r    <= trial[VW-1:0];
          quotient <= {quotient[DW-2:0], 1'b0};
        end
        if (cnt_r == CW'(1)) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end
endmodule // nam_div

/* dv/nam_properties.sv */
`timescale 1ns/1ns
module nam_props (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        mains_cycle_end,
  input wire logic        burst_end,
  input wire logic [15:0] alarm_cond_in,
  input wire logic        stop_fire,
  input wire logic [15:0] alarm_detect_set,
  input wire logic [15:0] alarm_signal_set,
  input wire logic        ref_capture_done
);
  // bits 10, 11, 14 come from internal detectors
  localparam logic [15:0] EXT = 16'hB3FF;
  logic [7:0] win_cnt_r;

  // lenient: any window end restarts the count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) win_cnt_r <= 8'hFF;
    else if (mains_cycle_end || burst_end) win_cnt_r <= 8'h00;
    else if (win_cnt_r != 8'hFF) win_cnt_r <= win_cnt_r + 8'h01;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest && ce;
  endsequence
  sequence ans_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  wait_one_a: assert property (req_s |=> ans_s)
    else $error("bus answer not one wait state");
  ack_read_a: assert property (
    !avs_waitrequest && avs_read && avs_address == nam_pkg::REG_ACK |-> avs_readdata == 32'h0)
    else $error("acknowledge reads nonzero");
  det_cause_a: assert property (
    ce |=> (alarm_detect_set & ~$past(alarm_cond_in) & EXT) == 16'h0)
    else $error("detect without condition");
  det_sig_a: assert property (
    (alarm_detect_set & ~alarm_signal_set) == 16'h0)
    else $error("detect without signal");
  sig_rise_a: assert property (
    ce |=> (alarm_signal_set & ~$past(alarm_signal_set) & ~alarm_detect_set) == 16'h0)
    else $error("signal rose without detect");
  ack_hold_a: assert property (
    ce |=> ($past(alarm_signal_set) & ~alarm_signal_set & $past(alarm_cond_in) & EXT) == 16'h0)
    else $error("signal cleared with condition present");
  stop_cause_a: assert property (
    stop_fire |-> (alarm_signal_set | $past(alarm_signal_set)) != 16'h0)
    else $error("stop without signal");
  done_win_a: assert property (
    $rose(ref_capture_done) |-> win_cnt_r <= 8'h3C)
    else $error("capture done far from window end");
endmodule // nam_props

bind nam_top nam_props nam_props_i (.mclk, .rst_n, .ce, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .mains_cycle_end, .burst_end, .alarm_cond_in, .stop_fire,
  .alarm_detect_set, .alarm_signal_set, .ref_capture_done);

/* dv/nam_front.sv */
`timescale 1ns/1ns
module nam_front #(
  parameter int WIN = 64
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire nam_pkg::nam_meas_t lvl,
  output logic                    meas_valid,
  output nam_pkg::nam_meas_t      meas,
  output logic                    mains_cycle_end,
  output logic                    burst_end
);
  int cnt_r;

  // burst period twice the mains cycle, out of phase with it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 0;
      meas_valid <= 1'b0;
      meas <= '0;
      mains_cycle_end <= 1'b0;
      burst_end <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 1;
      meas_valid <= (cnt_r % 4) == 0;
      if ((cnt_r % 4) == 0) meas <= lvl;
      mains_cycle_end <= (cnt_r % WIN) == WIN - 1;
      burst_end <= (cnt_r % (2 * WIN)) == WIN + 7;
    end
  end
endmodule // nam_front

/* dv/network_alarm_manager_tb.sv */
`timescale 1ns/1ns
module network_alarm_manager_tb;
  logic               mclk;
  logic               rst_n;
  logic               ce;
  logic [3:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               meas_valid;
  nam_pkg::nam_meas_t meas;
  nam_pkg::nam_meas_t lvl;
  logic               mains_cycle_end;
  logic               burst_end;
  logic [15:0]        cond;
  logic               stop_fire;
  logic [15:0]        det;
  logic [15:0]        sig;
  logic               done;
  logic [16:0]        obs;
  logic [31:0]        d;
  logic [15:0]        r;
  logic [15:0]        pc;
  logic [15:0]        dm;
  logic [15:0]        sm;
  logic [31:0]        u;
  int                 n_errors;
  int                 tests_run;
  logic [31:0] rv [9] = '{32'h2, 32'h1000, 32'h1000, 32'h14, 32'h78, 32'h2, 32'h0, 32'h0, 32'h0};
  logic [31:0] uv [4] = '{32'h4, 32'h32, 32'h33, 32'h5};
  int          nq [$] = '{1, 3, 2};
  int          zq [$] = '{32'h94, 32'h1BB, 32'h100};

  assign obs = {done, det};

  always #2 mclk = ~mclk;

  nam_top nam_top_i (.mclk, .rst_n, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .meas_valid, .meas, .mains_cycle_end, .burst_end,
    .alarm_cond_in(cond), .stop_fire, .alarm_detect_set(det), .alarm_signal_set(sig),
    .ref_capture_done(done));
  nam_front nam_front_i (.mclk, .rst_n, .lvl, .meas_valid, .meas, .mains_cycle_end, .burst_end);

  function automatic logic [15:0] lf(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic finish_test();
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int k;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k == 20) begin
      n_errors++;
      finish_test();
    end
  endtask

  // window plus a 42-cycle divide fits well inside the bound
  task automatic wfor(input int b, input logic v);
    int k;
    for (k = 0; k < 400 && obs[b] !== v; k++) @(posedge mclk);
    if (k == 400) begin
      n_errors++;
      finish_test();
    end
  endtask

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    cond = 16'h0;
    lvl = '0;
    n_errors = 0;
    tests_run = 0;
    r = 16'h0062;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int j = 0; j < 9; j++) begin
      bus(1'b0, j[3:0], 32'h0);
      chk(d, rv[j]);
    end
    u = 32'h14;
    foreach (uv[j]) begin
      bus(1'b1, nam_pkg::REG_UNB, uv[j]);
      bus(1'b0, nam_pkg::REG_UNB, 32'h0);
      if (uv[j] >= 5 && uv[j] <= 50) u = uv[j];
      chk(d, u);
    end
    bus(1'b1, nam_pkg::REG_DIS, 32'h3);
    bus(1'b1, nam_pkg::REG_LATCH, 32'hF0);
    bus(1'b1, nam_pkg::REG_STOP, 32'h10);
    pc = 16'h0;
    sm = 16'h0;
    repeat (60) begin
      @(posedge mclk);
      r = lf(r);
      cond <= r;
      #1;
      dm = pc & 16'hB3FC;
      sm = dm | (sm & 16'h00F0);
      chk(det, dm);
      chk(sig, sm);
      pc = r;
    end
    @(posedge mclk);
    cond <= 16'h0030;
    repeat (3) @(posedge mclk);
    chk(stop_fire, 1'b1);
    cond <= 16'h0020;
    bus(1'b1, nam_pkg::REG_ACK, 32'h30);
    repeat (3) @(posedge mclk);
    chk(sig & 16'h0030, 16'h0020);
    chk(stop_fire, 1'b0);
    cond <= 16'h0030;
    @(posedge mclk);
    cond <= 16'h0020;
    repeat (3) @(posedge mclk);
    chk(sig & 16'h0030, 16'h0030);
    bus(1'b0, nam_pkg::REG_ACK, 32'h0);
    chk(d, 32'h0);
    cond <= 16'h0;
    lvl.v <= {3{16'h0C00}};
    lvl.i <= {16'h0C00, 16'h0600, 16'h0C00};
    bus(1'b1, nam_pkg::REG_CTRL, 32'h102);
    repeat (200) @(posedge mclk);
    chk(done, 1'b0);
    chk(det[11], 1'b1);
    bus(1'b0, nam_pkg::REG_STATUS, 32'h0);
    chk(d, 32'h0);
    bus(1'b1, nam_pkg::REG_CTRL, 32'h0);
    repeat (12) @(posedge mclk);
    chk(det[11], 1'b0);
    lvl.i <= {3{16'h0C00}};
    foreach (nq[j]) begin
      bus(1'b1, nam_pkg::REG_CTRL, 32'h100 | nq[j]);
      repeat (2) @(posedge mclk);
      wfor(16, 1'b1);
      chk(done, 1'b1);
      bus(1'b0, nam_pkg::REG_ZREF0, 32'h0);
      chk(d, zq[j]);
    end
    for (int j = 1; j < 3; j++) begin
      bus(1'b0, nam_pkg::REG_ZREF0 + j[3:0], 32'h0);
      chk(d, 32'h100);
    end
    lvl.i <= {16'h0C00, 16'h0C00, 16'h0600};
    wfor(10, 1'b1);
    chk(det[10], 1'b1);
    lvl.v <= {3{16'h0300}};
    wfor(10, 1'b0);
    chk(det[10], 1'b0);
    lvl.v <= {3{16'h0C00}};
    lvl.i <= {3{16'h1400}};
    wfor(14, 1'b1);
    chk(det[14], 1'b1);
    bus(1'b1, nam_pkg::REG_CTRL, 32'h12);
    lvl.i <= {16'h0600, 16'h0C00, 16'h0C00};
    wfor(10, 1'b1);
    chk(det[10], 1'b1);
    finish_test();
  end
endmodule // network_alarm_manager_tb
